// >>> design/ppr_pkg.sv
// parallel poll response: shared constants and field layout
// assumes a byte-wide aux mode register write strobe on clk_sys
package pp_pkg;
  // aux mode register layout
  localparam int PP_CODE_HI = 7;
  localparam int PP_CODE_LO = 5;
  localparam int PP_VAL_HI = 4;
  localparam int PP_VAL_LO = 0;
  localparam logic [2:0] PP_CODE_POLL_CFG = 3'h3;
  // configuration field positions
  localparam int PP_BIT_DISABLE = 4;
  localparam int PP_BIT_SENSE = 3;
  localparam int PP_SEL_HI = 2;
  localparam int PP_SEL_LO = 0;
  // reset value: unconfigured, so no response until loaded
  localparam logic [4:0] PP_CFG_RESET = 5'h10;
  localparam int PP_DIO_W = 8;
endpackage

// >>> design/ppr_cfg_if.sv
// carrier for the decoded configuration between store and responder
// assumes one clk_sys domain
`timescale 1ns/1ps
interface pp_cfg_if;
  logic disable_flag;
  logic sense;
  logic [2:0] line_sel;
  modport store (output disable_flag, output sense, output line_sel);
  modport user (input disable_flag, input sense, input line_sel);
endinterface

// >>> design/ppr_cfg_store.sv
// write-only poll configuration store loaded through the aux mode register
// assumes aux_wr is a one-cycle strobe on clk_sys
`timescale 1ns/1ps
module pp_cfg_store
  import pp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic aux_wr,
  input wire logic [7:0] aux_data,
  pp_cfg_if.store cfg
);
  logic [4:0] poll_config_reg;
  wire hit = aux_wr && (aux_data[PP_CODE_HI:PP_CODE_LO] == PP_CODE_POLL_CFG); // R10
  wire [4:0] next_cfg = hit ? aux_data[PP_VAL_HI:PP_VAL_LO] : poll_config_reg;

  // held until next write or reset; no read path exists
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      poll_config_reg <= PP_CFG_RESET; // R13
    end else if (ce) begin
      poll_config_reg <= next_cfg; // R4 R13
    end
  end

  assign cfg.disable_flag = poll_config_reg[PP_BIT_DISABLE];
  assign cfg.sense = poll_config_reg[PP_BIT_SENSE];
  assign cfg.line_sel = poll_config_reg[PP_SEL_HI:PP_SEL_LO];

  a_cfg_load_hit: assert property (@(posedge clk_sys) disable iff (rst) // R10
    (ce && hit) |=> poll_config_reg == $past(aux_data[PP_VAL_HI:PP_VAL_LO]))
    else $error("poll config not loaded");
  a_cfg_hold_else: assert property (@(posedge clk_sys) disable iff (rst) // R13
    !(ce && hit) |=> $stable(poll_config_reg))
    else $error("poll config changed without write");
endmodule // pp_cfg_store

// >>> design/ppr_poll_resp.sv
// parallel poll configuration and response for the talker listener core
// assumes poll_active and ist come from core logic on clk_sys
// Summary of operation
// R1: enabled device answers polls per sense, line, status
// R2: disabled device never drives a data line; outside a poll dio_oe still follows data_oe
// R3: host clears sense and line when disabling
// R4: enabling write acts like a received enable message
// R5: sense one: pull line when status is one
// R6: sense zero: pull line when status is zero
// R7: line code is line number minus one
// R8: three-state normally, open-collector during poll response
// R9: all-zero config answers on line one if status zero
// R10: code 011 in upper bits loads config
// R11: no host writes under remote configuration
// R12: host loads valid config before local poll
// R13: config held until rewrite or reset, unreadable
`timescale 1ns/1ps
module pp_poll_resp
  import pp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic aux_wr,
  input wire logic [7:0] aux_data,
  input wire logic poll_active,
  input wire logic ist,
  input wire logic data_oe,
  input wire logic [PP_DIO_W-1:0] data_out,
  output logic [PP_DIO_W-1:0] dio_out,
  output logic [PP_DIO_W-1:0] dio_oe,
  output logic poll_responding
);
  // ***************************************
  // configuration store
  // ***************************************
  pp_cfg_if cfg_bus ();
  pp_cfg_store i_pp_cfg_store (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .aux_wr(aux_wr),
    .aux_data(aux_data),
    .cfg(cfg_bus.store)
  );

  // ***************************************
  // response decode
  // ***************************************
  // status matches sense: xnor covers both phases
  wire cfg_enabled = !cfg_bus.disable_flag; // R1 R2
  wire status_match = ~(cfg_bus.sense ^ ist); // R5 R6
  wire respond = poll_active && cfg_enabled && status_match; // R1 R2 R9
  // decoded again here only so the checks can see the write
  wire cfg_write = aux_wr && (aux_data[PP_CODE_HI:PP_CODE_LO] == PP_CODE_POLL_CFG); // R10
  wire [PP_DIO_W-1:0] line_onehot;
  wire [PP_DIO_W-1:0] next_oe;
  wire [PP_DIO_W-1:0] next_out;
  genvar i;
  generate
    for (i = 0; i < PP_DIO_W; i++) begin : g_line
      assign line_onehot[i] = (cfg_bus.line_sel == 3'(i)); // R7
      // open collector: only the enable moves, the value stays low
      assign next_oe[i] = poll_active ? (respond && line_onehot[i]) : data_oe; // R8
      assign next_out[i] = poll_active ? 1'h0 : data_out[i]; // R8
    end
  endgenerate

  // ***************************************
  // pin registers
  // ***************************************
  // one-cycle latency after poll or status change
  // reset ignores ce so a frozen core still comes up unconfigured
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dio_oe <= '0;
      dio_out <= '0;
      poll_responding <= 1'h0;
    end else if (ce) begin
      dio_oe <= next_oe; // R8
      dio_out <= next_out; // R8
      poll_responding <= respond; // R1
    end
  end

  // ***************************************
  // checks: reset and configuration
  // ***************************************
  a_reset_pins_quiet: assert property (@(posedge clk_sys) // R2
    rst
    |=> dio_oe == '0 && dio_out == '0 && !poll_responding)
    else $error("pins not quiet after reset");

  a_reset_cfg_off: assert property (@(posedge clk_sys) // R13
    rst
    |=> {cfg_bus.disable_flag, cfg_bus.sense, cfg_bus.line_sel} == PP_CFG_RESET)
    else $error("config not unconfigured after reset");

  a_cfg_write_load: assert property (@(posedge clk_sys) disable iff (rst) // R4
    (ce && cfg_write)
    |=> {cfg_bus.disable_flag, cfg_bus.sense, cfg_bus.line_sel} == $past(aux_data[PP_VAL_HI:PP_VAL_LO]))
    else $error("config write not applied");

  a_cfg_sense_load: assert property (@(posedge clk_sys) disable iff (rst) // R4
    (ce && cfg_write && !aux_data[PP_BIT_DISABLE])
    |=> cfg_bus.sense == $past(aux_data[PP_BIT_SENSE]) && cfg_bus.line_sel == $past(aux_data[PP_SEL_HI:PP_SEL_LO]))
    else $error("enable write fields lost");

  a_disable_write: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (ce && cfg_write && aux_data[PP_BIT_DISABLE])
    |=> cfg_bus.disable_flag)
    else $error("disabling write ignored");

  a_enable_write_act: assert property (@(posedge clk_sys) disable iff (rst) // R4
    (ce && cfg_write && !aux_data[PP_BIT_DISABLE])
    |=> !cfg_bus.disable_flag)
    else $error("enable write ignored");

  a_other_code_skip: assert property (@(posedge clk_sys) disable iff (rst) // R10
    (aux_wr && !cfg_write)
    |=> $stable(cfg_bus.disable_flag) && $stable(cfg_bus.sense) && $stable(cfg_bus.line_sel))
    else $error("config changed by another code");

  a_cfg_held: assert property (@(posedge clk_sys) disable iff (rst) // R13
    !(ce && cfg_write)
    |=> $stable(cfg_bus.disable_flag) && $stable(cfg_bus.sense) && $stable(cfg_bus.line_sel))
    else $error("config changed without write");

  a_cfg_frozen_ce: assert property (@(posedge clk_sys) disable iff (rst) // R13
    !ce
    |=> $stable(cfg_bus.disable_flag) && $stable(cfg_bus.sense) && $stable(cfg_bus.line_sel))
    else $error("config moved while clock enable low");

  // ***************************************
  // checks: poll response
  // ***************************************
  a_disabled_no_drive: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (ce && poll_active && cfg_bus.disable_flag)
    |=> dio_oe == '0)
    else $error("driven while disabled");

  a_disabled_no_flag: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (ce && poll_active && cfg_bus.disable_flag)
    |=> !poll_responding)
    else $error("responding while disabled");

  a_enabled_takes_part: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (ce && poll_active && cfg_enabled)
    |=> poll_responding == $past(status_match))
    else $error("enabled device not answering");

  a_respond_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (ce && respond)
    |=> poll_responding)
    else $error("response flag missing");

  a_in_phase_resp: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (ce && poll_active && cfg_enabled && cfg_bus.sense)
    |=> (dio_oe != '0) == $past(ist))
    else $error("in-phase response wrong");

  a_rev_phase_resp: assert property (@(posedge clk_sys) disable iff (rst) // R6
    (ce && poll_active && cfg_enabled && !cfg_bus.sense)
    |=> (dio_oe != '0) == !$past(ist))
    else $error("reverse-phase response wrong");

  a_resp_line_sel: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (ce && respond)
    |=> dio_oe == (8'h01 << $past(cfg_bus.line_sel)) && dio_out == '0)
    else $error("wrong responding line");

  a_line_code_two: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (ce && respond && cfg_bus.line_sel == 3'h2)
    |=> dio_oe == 8'h04)
    else $error("code two not on line three");

  a_one_line_only: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (ce && poll_active)
    |=> $onehot0(dio_oe))
    else $error("more than one line pulled");

  a_zero_cfg_line1: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (ce && poll_active && !ist && cfg_enabled && !cfg_bus.sense && cfg_bus.line_sel == 3'h0)
    |=> dio_oe == 8'h01)
    else $error("zero config not on line one");

  a_zero_cfg_quiet: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (ce && poll_active && ist && cfg_enabled && !cfg_bus.sense && cfg_bus.line_sel == 3'h0)
    |=> dio_oe == '0)
    else $error("zero config answers on status one");

  a_open_collector: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (ce && poll_active)
    |=> dio_out == '0)
    else $error("poll drives high");

  a_flag_follows_oe: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (ce && poll_active)
    |=> poll_responding == (dio_oe != '0))
    else $error("response flag and enable disagree");

  // ***************************************
  // checks: normal drive and clock enable
  // ***************************************
  a_idle_three_state: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (ce && !poll_active)
    |=> dio_oe == ($past(data_oe) ? '1 : '0))
    else $error("normal drive enable wrong");

  a_idle_data_out: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (ce && !poll_active)
    |=> dio_out == $past(data_out))
    else $error("normal data byte wrong");

  a_idle_no_flag: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (ce && !poll_active)
    |=> !poll_responding)
    else $error("responding outside a poll");

  a_pins_frozen_ce: assert property (@(posedge clk_sys) disable iff (rst) // R8
    !ce
    |=> $stable(dio_oe) && $stable(dio_out) && $stable(poll_responding))
    else $error("pins moved while clock enable low");
endmodule // pp_poll_resp

// >>> verif/ppr_ctrl_model.sv
// bus controller model: runs polls and resolves the dio lines
// assumes a pull-up on every dio line
`timescale 1ns/1ps
module pp_ctrl_model (
  input wire logic clk_sys,
  input wire logic poll_req,
  input wire logic [7:0] dio_out,
  input wire logic [7:0] dio_oe,
  output logic poll_active,
  output wire logic [7:0] dio_bus
);
  always @(posedge clk_sys) begin
    poll_active <= poll_req;
  end
  // released lines float high, so a stale value never shows
  assign dio_bus = dio_out | ~dio_oe;
endmodule // pp_ctrl_model

// >>> verif/tb_ppr_poll_resp.sv
// testbench: config writes through aux mode register, then polls
// assumes 20 MHz clk_sys and the controller model on the dio side
`timescale 1ns/1ps
module tb_pp_poll_resp;
  import pp_pkg::*;
  logic clk_sys = 1'h0, rst = 1'h1, ce = 1'h1, aux_wr = 1'h0, ist = 1'h0, data_oe = 1'h0, poll_req = 1'h0;
  logic [7:0] aux_data = 8'h00, data_out = 8'h00, dio_out, dio_oe, dio_bus, exp;
  logic poll_active, poll_responding;
  int fail_count = 0, n_tests = 0;
  pp_poll_resp i_pp_poll_resp (.clk_sys, .rst, .ce, .aux_wr, .aux_data, .poll_active, .ist,
    .data_oe, .data_out, .dio_out, .dio_oe, .poll_responding);
  pp_ctrl_model i_pp_ctrl_model (.clk_sys, .poll_req, .dio_out, .dio_oe, .poll_active, .dio_bus);
  initial forever #25 clk_sys = ~clk_sys;
  task chk(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] d);
    @(negedge clk_sys);
    aux_data = d;
    aux_wr = 1'h1;
    @(negedge clk_sys);
    aux_wr = 1'h0;
  endtask
  task poll(input logic s, input logic [7:0] want);
    @(negedge clk_sys);
    ist = s;
    poll_req = 1;
    repeat (2) @(negedge clk_sys);
    chk(dio_oe, want);
    chk(dio_bus, ~want);
    chk({7'h00, poll_responding}, {7'h00, |want});
    poll_req = 1'h0;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'h0;
    poll(1'h0, 8'h00);
    // every sense and line code, then disabled with zeroed fields
    // local configuration only, so host writes never fight a remote one
    for (int v = 0; v <= 16; v++) begin
      wr({PP_CODE_POLL_CFG, v[4:0]});
      for (int s = 0; s < 2; s++) begin
        exp = (v[4] || v[3] != s[0]) ? 8'h00 : 8'h01 << v[2:0];
        poll(s[0], exp);
      end
    end
    wr(8'h20);
    poll(1'h0, 8'h00);
    ce = 1'h0;
    wr(8'h60);
    ce = 1'h1;
    poll(1'h0, 8'h00);
    wr(8'h60);
    poll(1'h0, 8'h01);
    poll(1'h1, 8'h00);
    // mid-run reset must drop the loaded config back to unconfigured
    @(negedge clk_sys);
    rst = 1'h1;
    repeat (2) @(negedge clk_sys);
    rst = 1'h0;
    poll(1'h0, 8'h00);
    data_oe = 1'h1;
    data_out = 8'ha5;
    repeat (2) @(negedge clk_sys);
    chk(dio_oe, 8'hff);
    chk(dio_out, 8'ha5);
    stop_test;
  end
  initial begin
    #1000000;
    fail_count++;
    $display("CHECK FAILED %0t timeout", $time);
    stop_test;
  end
endmodule // tb_pp_poll_resp
